/* dta_pkg.sv */
// Package for the dual threshold alarm monitor: register map, fields, encodings
package dta_pkg;
    // Register addresses, 16-bit registers on even byte addresses
    localparam logic [6:0] ADDR_ALARM1_THRESHOLD    = 7'h26;
    localparam logic [6:0] ADDR_ALARM2_THRESHOLD    = 7'h28;
    localparam logic [6:0] ADDR_ALARM1_SAMPLE_COUNT = 7'h2a;
    localparam logic [6:0] ADDR_ALARM2_SAMPLE_COUNT = 7'h2c;
    localparam logic [6:0] ADDR_ALARM_CONFIG        = 7'h2e;
    localparam logic [6:0] ADDR_DIAGNOSTIC_STATUS   = 7'h3c;

    // Reset values
    localparam logic [15:0] RESET_ALARM_REG = 16'h0000;

    // Threshold register fields
    localparam int THR_POLARITY_BIT = 15;
    localparam int THR_VALUE_MSB    = 13;
    localparam int THR_VALUE_W      = 14;

    // Sample count field
    localparam int SMPL_COUNT_W = 8;

    // Configuration register fields
    localparam int CFG_SRC2_LSB     = 12;
    localparam int CFG_SRC1_LSB     = 8;
    localparam int CFG_DYN2_BIT     = 7;
    localparam int CFG_DYN1_BIT     = 6;
    localparam int CFG_FILTER_BIT   = 4;
    localparam int CFG_IND_EN_BIT   = 2;
    localparam int CFG_IND_POL_BIT  = 1;
    localparam int CFG_IND_LINE_BIT = 0;

    // Status register fields
    localparam int STAT_ALARM1_BIT = 8;
    localparam int STAT_ALARM2_BIT = 9;

    // Source select encodings
    localparam logic [3:0] SRC_DISABLE = 4'h0;
    localparam logic [3:0] SRC_GYRO_X  = 4'h1;
    localparam logic [3:0] SRC_GYRO_Y  = 4'h2;
    localparam logic [3:0] SRC_GYRO_Z  = 4'h3;
    localparam logic [3:0] SRC_ACCL_X  = 4'h4;
    localparam logic [3:0] SRC_ACCL_Y  = 4'h5;
    localparam logic [3:0] SRC_ACCL_Z  = 4'h6;
    localparam logic [3:0] SRC_TEMP    = 4'h7;

    // Sample history depth bound, counts up to 255
    localparam int HIST_DEPTH = 256;
endpackage

/* dta_cfg_if.sv */
// Interface carrying one alarm's settings from the register file to its channel
`timescale 1ns/10ps
interface dta_cfg_if;
    logic [15:0] threshold;
    logic [7:0]  sample_count;
    logic [3:0]  source;
    logic        dynamic;
    logic        filtered;
    logic        sample_valid;
    logic [15:0] sample;
    logic        alarm_hit;
    modport ctrl (output threshold, output sample_count, output source, output dynamic,
                  output filtered, output sample_valid, output sample, input alarm_hit);
    modport chan (input threshold, input sample_count, input source, input dynamic,
                  input filtered, input sample_valid, input sample, output alarm_hit);
endinterface

/* dta_alarm_channel.sv */
// One alarm channel: sample history and static or dynamic comparison
`timescale 1ns/10ps
module dta_alarm_channel
    import dta_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Settings and sample in, result out
    dta_cfg_if.chan  cfg
);
    // Pointer is eight bits wide, so the ring must hold exactly 256 entries
    if (DEPTH != 256) begin : g_depth_check
        $error("dta_alarm_channel: DEPTH must be 256");
    end

    logic [15:0] hist_mem [DEPTH];
    logic [7:0]  wr_ptr_reg;
    logic        hit_reg;

    // Counts of zero and one both mean a single sample back
    wire  [7:0]  eff_count = (cfg.sample_count < 8'h02) ? 8'h01 : cfg.sample_count;
    wire  [7:0]  rd_ptr    = wr_ptr_reg - eff_count;
    wire  [13:0] thr       = cfg.threshold[THR_VALUE_MSB:0];
    wire         above     = cfg.threshold[THR_POLARITY_BIT];
    // Data compared in the source's own 14-bit signed format
    wire  signed [14:0] cur_val  = {cfg.sample[13], cfg.sample[13:0]};
    wire  signed [14:0] old_val  = {hist_mem[rd_ptr][13], hist_mem[rd_ptr][13:0]};
    wire  signed [14:0] thr_val  = {thr[13], thr};
    wire  signed [15:0] delta    = 16'(cur_val) - 16'(old_val);
    wire  signed [15:0] thr_wide = 16'(thr_val);
    wire  signed [15:0] subject  = cfg.dynamic ? delta : 16'(cur_val);
    wire         cmp_hit   = above ? (subject > thr_wide) : (subject < thr_wide);
    // codes above temperature select nothing, so they disable the alarm too
    wire         enabled   = (cfg.source != SRC_DISABLE) && (cfg.source <= SRC_TEMP);

    // History ring, written once per sample
    always_ff @(posedge clk) begin
        if (cfg.sample_valid) begin
            hist_mem[wr_ptr_reg] <= cfg.sample;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr_reg <= 8'h00;
            hit_reg    <= 1'b0;
        end else if (cfg.sample_valid) begin
            wr_ptr_reg <= wr_ptr_reg + 8'h01;
            hit_reg    <= enabled & cmp_hit;
        end
    end

    assign cfg.alarm_hit = hit_reg;
endmodule

/* dta_alarm_monitor.sv */
// Dual threshold alarm monitor: alarm registers, source routing, status and indicator
//
// Notes on behaviour
// - Static mode compares the selected source against its own threshold register.
// - Threshold bit 15 picks direction: one means above, zero means below.
// - Threshold value is bits 13:0 in source format; bit 14 unused.
// - Dynamic mode compares change over the sample count against the threshold.
// - Sample count is low byte; zero and one both mean one sample.
// - Alarm 2 source bits 15:12: off, gyro x/y/z, accel x/y/z, temperature.
// - Alarm 1 source bits 11:8 use the same encoding.
// - Config bit 7 and 6 make alarm 2 and 1 dynamic.
// - Config bit 4 selects filtered data for both alarms.
// - Config bit 2 enables the hardware indicator output.
// - Config bit 1 sets indicator active level, one meaning high.
// - Config bit 0 routes indicator to line two, else line one.
// - Status bit 8 reports alarm 1, bit 9 reports alarm 2.
// - All alarm registers reset to zero, leaving alarms disabled.
// - Status flags clear on read and return next sample if still active.
`timescale 1ns/10ps
module dta_alarm_monitor
    import dta_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        resetn,
    // Register access from the serial transport
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [6:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata,
    // Sensor samples, one strobe per internal sample
    input  wire logic        sample_strobe,
    input  wire logic [15:0] raw_gyro_x,
    input  wire logic [15:0] raw_gyro_y,
    input  wire logic [15:0] raw_gyro_z,
    input  wire logic [15:0] raw_accel_x,
    input  wire logic [15:0] raw_accel_y,
    input  wire logic [15:0] raw_accel_z,
    input  wire logic [15:0] raw_temp,
    input  wire logic [15:0] filt_gyro_x,
    input  wire logic [15:0] filt_gyro_y,
    input  wire logic [15:0] filt_gyro_z,
    input  wire logic [15:0] filt_accel_x,
    input  wire logic [15:0] filt_accel_y,
    input  wire logic [15:0] filt_accel_z,
    input  wire logic [15:0] filt_temp,
    // Indicator on the general-purpose lines
    output logic             gp_line_one_out,
    output logic             gp_line_one_oe_n,
    output logic             gp_line_two_out,
    output logic             gp_line_two_oe_n,
    // Alarm status for the diagnostic register
    output logic [1:0]       alarm_status
);
    logic [15:0] alarm1_threshold_reg;
    logic [15:0] alarm2_threshold_reg;
    logic [7:0]  alarm1_sample_count_reg;
    logic [7:0]  alarm2_sample_count_reg;
    logic [15:0] alarm_config_reg;
    logic [1:0]  status_reg;
    logic [1:0]  status_next;
    logic [15:0] rdata_reg;
    logic        ind_out_reg;
    logic        ind_line2_reg;
    logic        ind_en_reg;

    dta_cfg_if ch1 ();
    dta_cfg_if ch2 ();

    // Write decode
    wire wr_thr1  = reg_wr && (reg_addr == ADDR_ALARM1_THRESHOLD);
    wire wr_thr2  = reg_wr && (reg_addr == ADDR_ALARM2_THRESHOLD);
    wire wr_cnt1  = reg_wr && (reg_addr == ADDR_ALARM1_SAMPLE_COUNT);
    wire wr_cnt2  = reg_wr && (reg_addr == ADDR_ALARM2_SAMPLE_COUNT);
    wire wr_cfg   = reg_wr && (reg_addr == ADDR_ALARM_CONFIG);
    wire rd_stat  = reg_rd && (reg_addr == ADDR_DIAGNOSTIC_STATUS);

    // Config fields
    wire [3:0] src1     = alarm_config_reg[CFG_SRC1_LSB +: 4];
    wire [3:0] src2     = alarm_config_reg[CFG_SRC2_LSB +: 4];
    wire       dyn1     = alarm_config_reg[CFG_DYN1_BIT];
    wire       dyn2     = alarm_config_reg[CFG_DYN2_BIT];
    wire       filt     = alarm_config_reg[CFG_FILTER_BIT];
    wire       ind_en   = alarm_config_reg[CFG_IND_EN_BIT];
    wire       ind_pol  = alarm_config_reg[CFG_IND_POL_BIT];
    wire       ind_line = alarm_config_reg[CFG_IND_LINE_BIT];

    // Source routing shared by both channels
    function automatic logic [15:0] pick(input logic [3:0] sel, input logic use_filt,
            input logic [15:0] rgx, input logic [15:0] rgy, input logic [15:0] rgz,
            input logic [15:0] rax, input logic [15:0] ray, input logic [15:0] raz,
            input logic [15:0] rt, input logic [15:0] fgx, input logic [15:0] fgy,
            input logic [15:0] fgz, input logic [15:0] fax, input logic [15:0] fay,
            input logic [15:0] faz, input logic [15:0] ft);
        logic [15:0] v;
        v = 16'h0000;
        unique case (sel)
            SRC_GYRO_X: v = use_filt ? fgx : rgx;
            SRC_GYRO_Y: v = use_filt ? fgy : rgy;
            SRC_GYRO_Z: v = use_filt ? fgz : rgz;
            SRC_ACCL_X: v = use_filt ? fax : rax;
            SRC_ACCL_Y: v = use_filt ? fay : ray;
            SRC_ACCL_Z: v = use_filt ? faz : raz;
            SRC_TEMP:   v = use_filt ? ft : rt;
            default:    v = 16'h0000;
        endcase
        return v;
    endfunction

    wire [15:0] data1 = pick(src1, filt, raw_gyro_x, raw_gyro_y, raw_gyro_z,
                             raw_accel_x, raw_accel_y, raw_accel_z, raw_temp,
                             filt_gyro_x, filt_gyro_y, filt_gyro_z,
                             filt_accel_x, filt_accel_y, filt_accel_z, filt_temp);
    wire [15:0] data2 = pick(src2, filt, raw_gyro_x, raw_gyro_y, raw_gyro_z,
                             raw_accel_x, raw_accel_y, raw_accel_z, raw_temp,
                             filt_gyro_x, filt_gyro_y, filt_gyro_z,
                             filt_accel_x, filt_accel_y, filt_accel_z, filt_temp);

    // Channel settings
    // dynamic mode bits per alarm
    assign ch1.threshold    = alarm1_threshold_reg;
    assign ch1.sample_count = alarm1_sample_count_reg;
    assign ch1.source       = src1;
    assign ch1.dynamic      = dyn1;
    assign ch1.filtered     = filt;
    assign ch1.sample_valid = sample_strobe;
    assign ch1.sample       = data1;
    assign ch2.threshold    = alarm2_threshold_reg;
    assign ch2.sample_count = alarm2_sample_count_reg;
    assign ch2.source       = src2;
    assign ch2.dynamic      = dyn2;
    assign ch2.filtered     = filt;
    assign ch2.sample_valid = sample_strobe;
    assign ch2.sample       = data2;

    dta_alarm_channel #(
        .DEPTH (HIST_DEPTH)
    ) u_alarm1 (
        .clk    (clk),
        .resetn (resetn),
        .cfg    (ch1)
    );

    dta_alarm_channel #(
        .DEPTH (HIST_DEPTH)
    ) u_alarm2 (
        .clk    (clk),
        .resetn (resetn),
        .cfg    (ch2)
    );

    // Register writes
    // all alarm registers reset to zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alarm1_threshold_reg    <= RESET_ALARM_REG;
            alarm2_threshold_reg    <= RESET_ALARM_REG;
            alarm1_sample_count_reg <= RESET_ALARM_REG[7:0];
            alarm2_sample_count_reg <= RESET_ALARM_REG[7:0];
            alarm_config_reg        <= RESET_ALARM_REG;
        end else begin
            if (wr_thr1) alarm1_threshold_reg <= reg_wdata & 16'hbfff;
            if (wr_thr2) alarm2_threshold_reg <= reg_wdata & 16'hbfff;
            // only the low byte is kept
            if (wr_cnt1) alarm1_sample_count_reg <= reg_wdata[SMPL_COUNT_W-1:0];
            if (wr_cnt2) alarm2_sample_count_reg <= reg_wdata[SMPL_COUNT_W-1:0];
            // Unused config bits 5 and 3 read back as zero
            if (wr_cfg) alarm_config_reg <= reg_wdata & 16'hffd7;
        end
    end

    // Hit flags settle one cycle after the sample strobe
    logic sample_strobe_d;

    // clear on read; a new hit wins over the clear
    assign status_next = (rd_stat ? 2'b00 : status_reg) |
                         {ch2.alarm_hit & sample_strobe_d, ch1.alarm_hit & sample_strobe_d};

    // Strobe delayed to the edge at which the hit flags are valid
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sample_strobe_d <= 1'b0;
        end else begin
            sample_strobe_d <= sample_strobe;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            status_reg <= 2'b00;
        end else begin
            status_reg <= status_next;
        end
    end

    // Read mux, registered so data comes from flip-flops
    wire [15:0] rd_mux =
        (reg_addr == ADDR_ALARM1_THRESHOLD)    ? alarm1_threshold_reg :
        (reg_addr == ADDR_ALARM2_THRESHOLD)    ? alarm2_threshold_reg :
        (reg_addr == ADDR_ALARM1_SAMPLE_COUNT) ? {8'h00, alarm1_sample_count_reg} :
        (reg_addr == ADDR_ALARM2_SAMPLE_COUNT) ? {8'h00, alarm2_sample_count_reg} :
        (reg_addr == ADDR_ALARM_CONFIG)        ? alarm_config_reg :
        (reg_addr == ADDR_DIAGNOSTIC_STATUS)   ? {6'h00, status_reg, 8'h00} :
                                                 16'h0000;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= 16'h0000;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux;
        end
    end

    // Indicator follows the live alarm condition, not the clear-on-read flags,
    // so a status read does not blip the line
    wire any_hit = ch1.alarm_hit | ch2.alarm_hit;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ind_out_reg   <= 1'b0;
            ind_line2_reg <= 1'b0;
            ind_en_reg    <= 1'b0;
        end else begin
            // active level chosen by polarity bit
            ind_out_reg   <= ind_pol ? any_hit : ~any_hit;
            ind_line2_reg <= ind_line;
            ind_en_reg    <= ind_en;
        end
    end

    // Output enables are low while a line is driven
    assign gp_line_one_out  = ind_out_reg;
    assign gp_line_two_out  = ind_out_reg;
    assign gp_line_one_oe_n = ~(ind_en_reg & ~ind_line2_reg);
    assign gp_line_two_oe_n = ~(ind_en_reg & ind_line2_reg);
    assign reg_rdata        = rdata_reg;
    assign alarm_status     = status_reg;
endmodule

/* dta_alarm_monitor_asserts.sv */
// Port-level checks for the alarm monitor
`timescale 1ns/10ps
module dta_alarm_monitor_asserts
    import dta_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        resetn,
    // Register reads
    input wire logic        reg_rd,
    input wire logic [6:0]  reg_addr,
    input wire logic [15:0] reg_rdata,
    // Samples, flags and indicator
    input wire logic        sample_strobe,
    input wire logic [1:0]  alarm_status,
    input wire logic        gp_line_one_out,
    input wire logic        gp_line_one_oe_n,
    input wire logic        gp_line_two_out,
    input wire logic        gp_line_two_oe_n
);
    logic [2:0] gap_reg;
    logic [2:0] gap_next;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    // Edges since the last strobe; saturates so long idle spans stay quiet
    assign gap_next = sample_strobe ? 3'h0 : (gap_reg == 3'h7 ? gap_reg : gap_reg + 3'h1);
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gap_reg <= 3'h7;
        end else begin
            gap_reg <= gap_next;
        end
    end

    // Status read, and one far enough from a strobe that no flag can be set at once
    sequence stat_rd_s;
        reg_rd && reg_addr == ADDR_DIAGNOSTIC_STATUS;
    endsequence
    sequence quiet_rd_s;
        stat_rd_s ##0 gap_reg > 3'h2;
    endsequence

    one_line_a: assert property (gp_line_one_oe_n || gp_line_two_oe_n)
        else $error("both indicator lines driven");
    same_level_a: assert property (gp_line_one_out == gp_line_two_out)
        else $error("indicator lines disagree");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    status_read_a: assert property (
        stat_rd_s |=> reg_rdata == {6'h00, $past(alarm_status), 8'h00})
        else $error("status read does not match flags");
    flag_clear_a: assert property (quiet_rd_s |=> alarm_status == 2'b00)
        else $error("flags not cleared by status read");
    flag_cause_a: assert property (
        (alarm_status & ~$past(alarm_status)) != 2'b00 |-> gap_reg inside {3'h1, 3'h2})
        else $error("flag set without a recent sample");
    thr_spare_a: assert property (
        reg_rd && (reg_addr == ADDR_ALARM1_THRESHOLD || reg_addr == ADDR_ALARM2_THRESHOLD)
        |=> reg_rdata[14] == 1'b0)
        else $error("threshold bit 14 reads back set");
    cnt_upper_a: assert property (
        reg_rd && (reg_addr == ADDR_ALARM1_SAMPLE_COUNT || reg_addr == ADDR_ALARM2_SAMPLE_COUNT)
        |=> reg_rdata[15:8] == 8'h00)
        else $error("sample count upper byte reads back set");
endmodule

bind dta_alarm_monitor dta_alarm_monitor_asserts i_chk (
    .clk, .resetn, .reg_rd, .reg_addr, .reg_rdata, .sample_strobe, .alarm_status,
    .gp_line_one_out, .gp_line_one_oe_n, .gp_line_two_out, .gp_line_two_oe_n
);

/* dta_host_model.sv */
// Host model: register strobes out, indicator lines sensed back
`timescale 1ns/10ps
module dta_host_model (
    // Clock
    input  wire logic        clk,
    // Register strobes toward the monitor
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [6:0]       reg_addr,
    output logic [15:0]      reg_wdata,
    // Indicator pins from the monitor
    input  wire logic        gp_line_one_out,
    input  wire logic        gp_line_one_oe_n,
    input  wire logic        gp_line_two_out,
    input  wire logic        gp_line_two_oe_n,
    // Line levels as the host sees them
    output logic             line_one,
    output logic             line_two
);
    // A released line shows the inverse, so a stale level never passes as driven
    assign line_one = gp_line_one_oe_n ? ~gp_line_one_out : gp_line_one_out;
    assign line_two = gp_line_two_oe_n ? ~gp_line_two_out : gp_line_two_out;

    // Idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 16'h0000;
    end

    // One strobe cycle, raised and dropped just after an edge
    task automatic access(input logic wr, input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        #1;
        reg_wr = wr;
        reg_rd = !wr;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk);
        #1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    endtask
endmodule

/* tb.sv */
// Self-checking bench for the dual threshold alarm monitor
`timescale 1ns/10ps
module tb;
    import dta_pkg::*;
    logic        clk;
    logic        resetn;
    logic        reg_wr;
    logic        reg_rd;
    logic [6:0]  reg_addr;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        strobe;
    logic [15:0] s [14];
    logic [1:0]  alarm_status;
    logic        out1;
    logic        out2;
    logic        oe1_n;
    logic        oe2_n;
    logic        line1;
    logic        line2;
    logic [15:0] cfg;
    logic [15:0] thr1;
    logic [15:0] thr2;
    logic [31:0] e;
    logic [31:0] q [$];
    int          hv [$];
    int          k1;
    int          k2;
    int          num_errors;
    int          checks;

    // Clock at 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    dta_alarm_monitor i_dut (
        .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_strobe(strobe),
        .raw_gyro_x(s[0]), .raw_gyro_y(s[1]), .raw_gyro_z(s[2]), .raw_accel_x(s[3]),
        .raw_accel_y(s[4]), .raw_accel_z(s[5]), .raw_temp(s[6]), .filt_gyro_x(s[7]),
        .filt_gyro_y(s[8]), .filt_gyro_z(s[9]), .filt_accel_x(s[10]), .filt_accel_y(s[11]),
        .filt_accel_z(s[12]), .filt_temp(s[13]), .gp_line_one_out(out1),
        .gp_line_one_oe_n(oe1_n), .gp_line_two_out(out2), .gp_line_two_oe_n(oe2_n),
        .alarm_status(alarm_status)
    );
    dta_host_model i_host (
        .clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .gp_line_one_out(out1), .gp_line_one_oe_n(oe1_n), .gp_line_two_out(out2),
        .gp_line_two_oe_n(oe2_n), .line_one(line1), .line_two(line2)
    );

    task automatic check(input string n, input logic [15:0] x, input logic [15:0] g);
        checks++;
        if (g !== x) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask

    // Note the expected word, then issue the read
    task automatic rd_chk(input logic [6:0] a, input logic [15:0] x, input logic [15:0] m);
        q.push_back({m, x});
        i_host.access(1'b0, a, 16'h0000);
    endtask

    // Read results return in request order; masked bits are not judged
    always @(posedge clk) begin
        if (reg_rd === 1'b1) begin
            #2;
            e = q.pop_front();
            check("reg_rdata", e[15:0] & e[31:16], reg_rdata & e[31:16]);
        end
    end

    function automatic logic hit(input logic [15:0] t, input logic [3:0] src, input logic dyn,
                                 input int k, input int n);
        int i;
        int v;
        if (src == SRC_DISABLE || src > SRC_TEMP)
            return 1'b0;
        i = (cfg[CFG_FILTER_BIT] ? 7 : 0) + int'(src) - 1;
        v = hv[n * 14 + i];
        if (dyn)
            v = v - hv[(n - k) * 14 + i];
        return t[THR_POLARITY_BIT] ? v > int'($signed(t[13:0])) : v < int'($signed(t[13:0]));
    endfunction

    // Eight samples; early ones only fill the history for the change window
    task automatic run_block(input int from);
        int n;
        logic h1;
        logic h2;
        logic en;
        for (int j = 0; j < 8; j++) begin
            @(posedge clk);
            #1;
            strobe = 1'b1;
            n = hv.size() / 14;
            for (int i = 0; i < 14; i++) begin
                hv.push_back(int'($urandom_range(4000)) - 2000);
                s[i] = 16'(hv[n * 14 + i]);
            end
            @(posedge clk);
            #1;
            strobe = 1'b0;
            h1 = hit(thr1, cfg[11:8], cfg[CFG_DYN1_BIT], k1, n);
            h2 = hit(thr2, cfg[15:12], cfg[CFG_DYN2_BIT], k2, n);
            en = cfg[CFG_IND_EN_BIT];
            repeat (3) @(posedge clk);
            #1;
            if (j >= from) begin
                check("alarm_status", 16'({h2, h1}), 16'(alarm_status));
                check("oe_one_n", 16'(!(en && !cfg[0])), 16'(oe1_n));
                check("oe_two_n", 16'(!(en && cfg[0])), 16'(oe2_n));
                if (en)
                    check("line", 16'(cfg[1] ? h1 | h2 : !(h1 | h2)),
                          16'(cfg[0] ? line2 : line1));
            end
            rd_chk(ADDR_DIAGNOSTIC_STATUS, {6'h00, h2, h1, 8'h00},
                   j >= from ? 16'hffff : 16'h0000);
            check("status_cleared", 16'h0000, 16'(alarm_status));
        end
    endtask

    task automatic end_sim;
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence: reset values, spare bits, then randomised alarm blocks
    initial begin
        logic [15:0] c1;
        logic [15:0] c2;
        logic [6:0]  ra [6];
        logic [15:0] rm [6];
        ra = '{ADDR_ALARM1_THRESHOLD, ADDR_ALARM2_THRESHOLD, ADDR_ALARM1_SAMPLE_COUNT,
               ADDR_ALARM2_SAMPLE_COUNT, ADDR_ALARM_CONFIG, 7'h30};
        rm = '{16'hbfff, 16'hbfff, 16'h00ff, 16'h00ff, 16'hffd7, 16'h0000};
        num_errors = 0;
        checks = 0;
        resetn = 1'b0;
        strobe = 1'b0;
        cfg = 16'h0000;
        thr1 = 16'h0000;
        thr2 = 16'h0000;
        k1 = 1;
        k2 = 1;
        for (int i = 0; i < 14; i++)
            s[i] = 16'h0000;
        void'($urandom(32'h48a6268c));
        repeat (16) @(posedge clk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 6; i++)
            rd_chk(ra[i], 16'h0000, 16'hffff);
        run_block(0);
        for (int i = 0; i < 6; i++) begin
            i_host.access(1'b1, ra[i], 16'hffff);
            rd_chk(ra[i], rm[i], 16'hffff);
        end
        // Every source code on both alarms, modes and indicator bits at random
        for (int b = 0; b < 18; b++) begin
            thr1 = 16'($urandom_range(6000) - 3000) ^ 16'($urandom_range(3) << 14);
            thr2 = 16'($urandom_range(6000) - 3000) ^ 16'($urandom_range(3) << 14);
            c1 = {8'($urandom), 8'($urandom_range(5))};
            c2 = {8'($urandom), 8'($urandom_range(5))};
            k1 = c1[7:0] < 8'h02 ? 1 : int'(c1[7:0]);
            k2 = c2[7:0] < 8'h02 ? 1 : int'(c2[7:0]);
            cfg = {4'((b * 5 + 2) % 9), 4'(b % 9), 8'($urandom)};
            i_host.access(1'b1, ADDR_ALARM1_THRESHOLD, thr1);
            i_host.access(1'b1, ADDR_ALARM2_THRESHOLD, thr2);
            i_host.access(1'b1, ADDR_ALARM1_SAMPLE_COUNT, c1);
            i_host.access(1'b1, ADDR_ALARM2_SAMPLE_COUNT, c2);
            i_host.access(1'b1, ADDR_ALARM_CONFIG, cfg);
            run_block(5);
        end
        end_sim;
    end

    // Run needs about 1300 cycles; fifteen times that means a hang
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim;
    end
endmodule
